// ### hdl/psam_pkg.sv
// Constants, register map and carrier types for the program space access mapper.
// Assumes one clock domain and a synchronous active-high reset.
package psam_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses on the register bus)
    // ------------------------------------------------------------------
    localparam logic [7:0]  PSAM_TPS_OFF      = 8'h00;  // Table page
    localparam logic [7:0]  PSAM_VPS_OFF      = 8'h04;  // Visibility page
    localparam logic [7:0]  PSAM_CCR_OFF      = 8'h08;  // Core control
    localparam logic [7:0]  PSAM_STAT_OFF     = 8'h0c;  // Status, read only
    localparam logic [7:0]  PSAM_BREV_OFF     = 8'h10;  // Index in, mirrored index out

    localparam logic [7:0]  PSAM_TPS_RST      = 8'h00;
    localparam logic [7:0]  PSAM_VPS_RST      = 8'h00;
    localparam logic [15:0] PSAM_CCR_RST      = 16'h0000;
    localparam int          PSAM_CCR_VWE_BIT  = 2;      // Visibility window enable
    localparam int          PSAM_PAGE_MSB     = 7;      // Table page: configuration space
    localparam int          PSAM_EA_WIN_BIT   = 15;     // Upper half of data space

    // Status bits
    localparam int          PSAM_ST_BUSY_BIT  = 0;
    localparam int          PSAM_ST_TBL_BIT   = 1;
    localparam int          PSAM_ST_PM_BIT    = 2;

    // ------------------------------------------------------------------
    // Timing and sizes
    // ------------------------------------------------------------------
    localparam logic [1:0]  PSAM_XTRA_MOV     = 2'h0;   // Beyond the second fetch
    localparam logic [1:0]  PSAM_XTRA_OTHER   = 2'h1;
    localparam int          PSAM_BREV_BITS    = 4;      // 16-entry buffer

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_DATA_RD,
        OP_TBL_RD_LO,
        OP_TBL_RD_HI,
        OP_TBL_WR_LO,
        OP_TBL_WR_HI
    } psam_op_e;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_FETCH2,
        ST_CAPT,
        ST_XTRA,
        ST_RESP
    } psam_fsm_e;

    typedef struct packed {
        psam_op_e    op;
        logic        byte_mode;
        logic        is_mov;
        logic        in_repeat;
        logic [15:0] effective_address;
        logic [15:0] wdata;
    } psam_req_s;

    typedef struct packed {
        logic [22:0] word_addr;
        logic        cfg;
        logic        rd;
        logic        wr;
        logic [2:0]  be;
        logic [23:0] wdata;
    } psam_pm_s;

    typedef struct packed {
        psam_fsm_e   st;
        logic [7:0]  table_page_select;
        logic [7:0]  visibility_page_select;
        logic [15:0] core_control_reg;
        logic [PSAM_BREV_BITS-1:0] brev_idx;
        psam_req_s   req;
        logic        visibility_window_enable;
        logic [1:0]  xtra;
        psam_pm_s    pm;
        logic [15:0] rsp_data;
        logic        rsp_pm;
        logic        ack;
        logic [31:0] rdat;
    } psam_state_s;

endpackage : psam_pkg

// ### hdl/psam_bitrev.sv
// Mirror of an index for a bit-reversed buffer of 2**W entries.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module psam_bitrev #(
    parameter int W = 4
) (
    input  wire logic [W-1:0] idx_i,   // Normal index
    output logic      [W-1:0] rev_o    // Mirrored index
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_mirror
            assign rev_o[g] = idx_i[W-1-g];
        end
    endgenerate
endmodule : psam_bitrev
`default_nettype wire

// ### hdl/psam_rd_steer.sv
// Steering of a 24-bit program word onto the 16-bit data bus for reads.
// Combinational; the caller registers the result.
`timescale 1ns/10ps
`default_nettype none
module psam_rd_steer (
    input  wire logic        op_hi_i,      // Upper-byte table read
    input  wire logic        byte_mode_i,  // Byte access
    input  wire logic        byte_sel_i,   // Effective address bit 0
    input  wire logic        psv_i,        // Visibility window read
    input  wire logic [23:0] pm_word_i,    // Program word
    output logic      [15:0] data_o        // Steered data
);
    always_comb begin
        data_o = 16'h0000;
        if (psv_i) begin
            data_o = pm_word_i[15:0];
        end else if (!op_hi_i) begin
            if (!byte_mode_i) begin
                data_o = pm_word_i[15:0];
            end else begin
                data_o = {8'h00, byte_sel_i ? pm_word_i[15:8] : pm_word_i[7:0]};
            end
        end else begin
            // Phantom byte always reads zero
            if (!byte_mode_i || !byte_sel_i) begin
                data_o = {8'h00, pm_word_i[23:16]};
            end
        end
    end
endmodule : psam_rd_steer
`default_nettype wire

// ### hdl/psam_mapper.sv
// Program space access mapper: builds program addresses for table and
// visibility-window accesses and steers data between 16 and 24 bits.
// Assumes a synchronous program memory on clk_i: read data valid in the
// cycle after the one in which the read strobe is high.
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module psam_mapper
    import psam_pkg::*;
(
    input  wire logic        clk_i,             // 25 MHz clock
    input  wire logic        rst_i,             // Synchronous reset, high
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,          // Cycle
    input  wire logic        wb_stb_i,          // Strobe
    input  wire logic        wb_we_i,           // Write enable
    input  wire logic [7:0]  wb_adr_i,          // Byte address
    input  wire logic [3:0]  wb_sel_i,          // Byte lanes
    input  wire logic [31:0] wb_dat_i,          // Write data
    output logic      [31:0] wb_dat_o,          // Read data
    output logic             wb_ack_o,          // Acknowledge
    // Core side
    input  wire logic        core_req_valid_i,  // Access request
    input  wire psam_req_s   core_req_i,        // Request contents
    output logic             core_req_ready_o,  // Request taken when high
    output logic             core_rsp_valid_o,  // Completion pulse
    output logic      [15:0] core_rsp_data_o,   // Read data
    output logic             core_rsp_pm_o,     // Served by program memory
    output logic             core_tbl_active_o, // Table access in flight
    // Program memory side
    output psam_pm_s         pm_o,              // Address, strobes, write data
    input  wire logic [23:0] pm_rdata_i         // Program word read
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    psam_state_s s_reg;
    psam_state_s s_next;

    logic [15:0]               steer_data;
    logic [PSAM_BREV_BITS-1:0] brev_out;
    logic                      take;
    logic                      psv_hit;
    logic                      is_tbl;
    logic                      tbl_op_q;
    logic                      bus_req;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    psam_bitrev #(
        .W      (PSAM_BREV_BITS)
    ) u_bitrev (
        .idx_i  (s_reg.brev_idx),
        .rev_o  (brev_out)
    );

    psam_rd_steer u_steer (
        .op_hi_i     (s_reg.req.op == OP_TBL_RD_HI),
        .byte_mode_i (s_reg.req.byte_mode),
        .byte_sel_i  (s_reg.req.effective_address[0]),
        .psv_i       (s_reg.visibility_window_enable),
        .pm_word_i   (pm_rdata_i),
        .data_o      (steer_data)
    );

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    assign take     = core_req_valid_i && core_req_ready_o;
    assign is_tbl   = core_req_i.op != OP_DATA_RD;
    assign tbl_op_q = s_reg.req.op != OP_DATA_RD;
    assign bus_req  = wb_cyc_i && wb_stb_i;
    // Window hit: upper half of data space and enable bit set
    assign psv_hit  = core_req_i.effective_address[PSAM_EA_WIN_BIT]
                      && s_reg.core_control_reg[PSAM_CCR_VWE_BIT];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_next        = s_reg;
        s_next.ack    = 1'b0;
        s_next.pm.rd  = 1'b0;
        s_next.pm.wr  = 1'b0;

        // Register bus: answer one cycle after the request, write on ack edge
        if (bus_req && !s_reg.ack) begin
            s_next.ack = 1'b1;
            case (wb_adr_i)
                PSAM_TPS_OFF:  s_next.rdat = {24'h000000, s_reg.table_page_select};
                PSAM_VPS_OFF:  s_next.rdat = {24'h000000, s_reg.visibility_page_select};
                PSAM_CCR_OFF:  s_next.rdat = {16'h0000, s_reg.core_control_reg};
                PSAM_STAT_OFF: s_next.rdat = {29'h00000000, s_reg.rsp_pm,
                                              core_tbl_active_o, s_reg.st != ST_IDLE};
                PSAM_BREV_OFF: s_next.rdat = {20'h00000, brev_out,
                                              4'h0, s_reg.brev_idx};
                default:       s_next.rdat = 32'h00000000;
            endcase
        end
        if (bus_req && s_reg.ack && wb_we_i) begin
            case (wb_adr_i)
                PSAM_TPS_OFF: begin
                    if (wb_sel_i[0]) s_next.table_page_select = wb_dat_i[7:0];
                end
                PSAM_VPS_OFF: begin
                    if (wb_sel_i[0]) s_next.visibility_page_select = wb_dat_i[7:0];
                end
                PSAM_CCR_OFF: begin
                    if (wb_sel_i[0]) s_next.core_control_reg[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) s_next.core_control_reg[15:8] = wb_dat_i[15:8];
                end
                PSAM_BREV_OFF: begin
                    if (wb_sel_i[0]) s_next.brev_idx = wb_dat_i[PSAM_BREV_BITS-1:0];
                end
                default: begin
                end
            endcase
        end

        // Access sequencer; one access at a time, so a table access
        // in flight holds off any window read until it completes
        case (s_reg.st)
            ST_IDLE: begin
                if (take) begin
                    s_next.req    = core_req_i;
                    s_next.visibility_window_enable    = !is_tbl && psv_hit;
                    s_next.rsp_pm = is_tbl || psv_hit;
                    s_next.xtra   = (core_req_i.is_mov || core_req_i.in_repeat)
                                    ? PSAM_XTRA_MOV : PSAM_XTRA_OTHER;
                    if (is_tbl) begin
                        // Word index: address advances by two per word
                        s_next.pm.word_addr = {s_reg.table_page_select,
                                               core_req_i.effective_address[15:1]};
                        s_next.pm.cfg = s_reg.table_page_select[PSAM_PAGE_MSB];
                    end else begin
                        // Address bit 15 from page bit 0, bit 23 forced low
                        s_next.pm.word_addr = {1'b0, s_reg.visibility_page_select,
                                               core_req_i.effective_address[14:1]};
                        s_next.pm.cfg = 1'b0;
                    end
                    s_next.pm.be    = 3'h0;
                    s_next.pm.wdata = 24'h000000;
                    case (core_req_i.op)
                        OP_TBL_WR_LO: begin
                            s_next.pm.wr = 1'b1;
                            s_next.pm.wdata = {8'h00, core_req_i.byte_mode
                                               ? {2{core_req_i.wdata[7:0]}} : core_req_i.wdata};
                            s_next.pm.be = !core_req_i.byte_mode ? 3'h3
                                         : (core_req_i.effective_address[0] ? 3'h2 : 3'h1);
                        end
                        OP_TBL_WR_HI: begin
                            // Only path that writes the program upper byte
                            s_next.pm.wr = 1'b1;
                            s_next.pm.wdata = {core_req_i.wdata[7:0], 16'h0000};
                            s_next.pm.be = (core_req_i.byte_mode
                                            && core_req_i.effective_address[0]) ? 3'h0 : 3'h4;
                        end
                        default: begin
                            s_next.pm.rd = is_tbl || psv_hit;
                        end
                    endcase
                    s_next.st = (is_tbl || psv_hit) ? ST_FETCH : ST_RESP;
                    if (!is_tbl && !psv_hit) s_next.rsp_data = 16'h0000;
                end
            end
            ST_FETCH: begin
                if (s_reg.pm.wr) begin
                    s_next.st = ST_RESP;
                end else if (s_reg.visibility_window_enable) begin
                    s_next.pm.rd = 1'b1;
                    s_next.st = ST_FETCH2;
                end else begin
                    s_next.st = ST_CAPT;
                end
            end
            ST_FETCH2: begin
                s_next.st = ST_CAPT;
            end
            ST_CAPT: begin
                s_next.rsp_data = steer_data;
                s_next.st = (s_reg.visibility_window_enable && s_reg.xtra != 2'h0) ? ST_XTRA : ST_RESP;
            end
            ST_XTRA: begin
                s_next.xtra = s_reg.xtra - 2'h1;
                if (s_reg.xtra == 2'h1) s_next.st = ST_RESP;
            end
            ST_RESP: begin
                s_next.st = ST_IDLE;
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_reg                        <= '0;
            s_reg.st                     <= ST_IDLE;
            s_reg.table_page_select      <= PSAM_TPS_RST;
            s_reg.visibility_page_select <= PSAM_VPS_RST;
            s_reg.core_control_reg       <= PSAM_CCR_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_dat_o          = s_reg.rdat;
    assign wb_ack_o          = s_reg.ack;
    assign core_req_ready_o  = s_reg.st == ST_IDLE;
    assign core_rsp_valid_o  = s_reg.st == ST_RESP;
    assign core_rsp_data_o   = s_reg.rsp_data;
    assign core_rsp_pm_o     = s_reg.rsp_pm;
    assign core_tbl_active_o = (s_reg.st != ST_IDLE) && tbl_op_q;
    assign pm_o              = s_reg.pm;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    tbl_page_addr_a: assert property (
        take && is_tbl |=> pm_o.word_addr == {$past(s_reg.table_page_select),
                                              $past(core_req_i.effective_address[15:1])})
        else $error("Table address not page over effective address");

    cfg_select_a: assert property (
        take && is_tbl |=> pm_o.cfg == $past(s_reg.table_page_select[PSAM_PAGE_MSB]))
        else $error("Configuration select does not follow page top bit");

    win_addr_a: assert property (
        take && !is_tbl && psv_hit |=> pm_o.rd && !pm_o.cfg
            && pm_o.word_addr[21:14] == $past(s_reg.visibility_page_select))
        else $error("Window address not built from visibility page");

    win_bit15_a: assert property (
        pm_o.rd && s_reg.visibility_window_enable |-> pm_o.word_addr[22] == 1'b0
            && pm_o.word_addr[14] == s_reg.visibility_page_select[0])
        else $error("Window address bit 15 or 23 wrong");

    win_gate_a: assert property (
        take && !is_tbl && !psv_hit |=> !pm_o.rd && core_rsp_valid_o && !core_rsp_pm_o)
        else $error("Data read reached program memory without window hit");

    two_fetch_a: assert property (
        take && !is_tbl && psv_hit |=> pm_o.rd [*2] ##1 !pm_o.rd)
        else $error("Window read did not fetch twice");

    mov_extra_a: assert property (
        take && !is_tbl && psv_hit && core_req_i.is_mov |-> ##4 core_rsp_valid_o)
        else $error("Window move latency wrong");

    other_extra_a: assert property (
        take && !is_tbl && psv_hit && !core_req_i.is_mov && !core_req_i.in_repeat
            |-> !core_rsp_valid_o [*5] ##1 core_rsp_valid_o)
        else $error("Window non-move latency wrong");

    tbl_block_a: assert property (
        core_tbl_active_o |-> !s_reg.visibility_window_enable && !core_req_ready_o)
        else $error("Window access during table access");

    win_data_a: assert property (
        s_reg.st == ST_CAPT && s_reg.visibility_window_enable |=> core_rsp_data_o == $past(pm_rdata_i[15:0]))
        else $error("Window read data not low program word");

    phantom_a: assert property (
        core_rsp_valid_o && s_reg.req.op == OP_TBL_RD_HI |-> core_rsp_data_o[15:8] == 8'h00)
        else $error("Phantom byte not zero");

    brev_mirror_a: assert property (
        brev_out == {s_reg.brev_idx[0], s_reg.brev_idx[1], s_reg.brev_idx[2], s_reg.brev_idx[3]})
        else $error("Bit-reversed index wrong");

    // ------------------------------------------------------------------
    // Read steering, write guards and pulse shapes
    // ------------------------------------------------------------------
    // Memory word stands in the capture cycle, one cycle before completion
    low_word_a: assert property (
        core_rsp_valid_o && s_reg.req.op == OP_TBL_RD_LO && !s_reg.req.byte_mode
            |-> core_rsp_data_o == $past(pm_rdata_i[15:0]))
        else $error("Low word table read not passed through");

    low_byte_a: assert property (
        core_rsp_valid_o && s_reg.req.op == OP_TBL_RD_LO && s_reg.req.byte_mode
            |-> core_rsp_data_o == {8'h00, s_reg.req.effective_address[0]
                                    ? $past(pm_rdata_i[15:8]) : $past(pm_rdata_i[7:0])})
        else $error("Low byte table read picked wrong byte");

    high_word_a: assert property (
        core_rsp_valid_o && s_reg.req.op == OP_TBL_RD_HI && !s_reg.req.byte_mode
            |-> core_rsp_data_o == {8'h00, $past(pm_rdata_i[23:16])})
        else $error("High word table read wrong");

    high_byte_a: assert property (
        core_rsp_valid_o && s_reg.req.op == OP_TBL_RD_HI && s_reg.req.byte_mode
            |-> core_rsp_data_o[7:0] == (s_reg.req.effective_address[0]
                                         ? 8'h00 : $past(pm_rdata_i[23:16])))
        else $error("High byte table read wrong");

    upper_write_a: assert property (
        pm_o.wr && pm_o.be[2] |-> s_reg.req.op == OP_TBL_WR_HI)
        else $error("Upper program byte written by other than high table write");

    win_ro_a: assert property (
        s_reg.visibility_window_enable |-> !pm_o.wr)
        else $error("Window access wrote program memory");

    rsp_pulse_a: assert property (
        core_rsp_valid_o |=> !core_rsp_valid_o)
        else $error("Completion pulse longer than one cycle");

    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("Bus acknowledge longer than one cycle");

endmodule : psam_mapper
`default_nettype wire

// ### test/psam_pm_model.sv
// Program memory model facing the mapper's program memory port.
// Assumes pm_i is registered on clk_i; the word answers one cycle after rd.
`timescale 1ns/10ps
`default_nettype none
module psam_pm_model
    import psam_pkg::*;
(
    input  wire logic        clk_i,   // Clock
    input  wire psam_pm_s    pm_i,    // Address and strobes
    output logic      [23:0] rdata_o  // Program word
);
    // ------------------------------------------------------------------
    // Contents and read port
    // ------------------------------------------------------------------
    // Upper byte all ones or all zeros, as constants are stored
    function automatic logic [23:0] word_at(input logic [22:0] a, input logic c);
        return {{8{a[0]}}, a[15:0] ^ 16'h3c5a ^ {c, 15'h0}};
    endfunction : word_at

    initial rdata_o = 24'h0;
    // Idle bus shows the inverse of its last value, so the last word returns on every second idle cycle
    always @(posedge clk_i) begin
        rdata_o <= pm_i.rd ? word_at(pm_i.word_addr, pm_i.cfg) : ~rdata_o;
    end
endmodule : psam_pm_model
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the program space access mapper.
// Assumes psam_pm_model as program memory and a Wishbone master in this file.
`timescale 1ns/10ps
`default_nettype none
module testbench
    import psam_pkg::*;
;
    logic        clk, rst, wb_cyc, wb_stb, wb_we, wb_ack, req_valid;
    logic [7:0]  wb_adr, tps, vps;
    logic [31:0] wb_wdat, wb_rdat, seed, q;
    logic        ready, rsp_valid, rsp_pm, tbl_active, vwe;
    logic [15:0] rsp_data;
    logic [23:0] pm_rdata;
    psam_req_s   req;
    psam_pm_s    pm;
    int          mismatches, compares, cycles;
    logic [7:0]  probe [5];

    psam_mapper psam_mapper_inst (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
        .wb_ack_o(wb_ack), .core_req_valid_i(req_valid), .core_req_i(req), .core_req_ready_o(ready),
        .core_rsp_valid_o(rsp_valid), .core_rsp_data_o(rsp_data), .core_rsp_pm_o(rsp_pm),
        .core_tbl_active_o(tbl_active), .pm_o(pm), .pm_rdata_i(pm_rdata));
    psam_pm_model psam_pm_model_inst (.clk_i(clk), .pm_i(pm), .rdata_o(pm_rdata));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_wdat <= d;
        do @(posedge clk); while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    // Issue one core access and judge address, strobes, latency and data
    task automatic core(input psam_op_e op, input logic bm, mv, rp, input logic [15:0] ea, wd);
        int          n;
        logic        tb, pmx, hi, c;
        logic [22:0] ad;
        logic [23:0] w, m;
        logic [15:0] e;
        logic [2:0]  be;
        req <= '{op, bm, mv, rp, ea, wd};
        req_valid <= 1'b1;
        do @(posedge clk); while (ready !== 1'b1);
        req_valid <= 1'b0;
        tb = op != OP_DATA_RD;
        hi = op == OP_TBL_WR_HI || op == OP_TBL_RD_HI;
        pmx = tb || (ea[15] && vwe);
        c = tb && tps[7];
        ad = tb ? {tps, ea[15:1]} : {1'b0, vps, ea[14:1]};
        w = {{8{ad[0]}}, ad[15:0] ^ 16'h3c5a ^ {c, 15'h0}};
        be = hi ? {~(bm & ea[0]), 2'b00} : (bm ? {1'b0, ea[0], ~ea[0]} : 3'b011);
        m = {{8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n == 1) check(tbl_active, tb);
            if (pm.rd === 1'b1 || pm.wr === 1'b1) check({pm.cfg, pm.word_addr}, {c, ad});
            if (pm.wr === 1'b1) check({pm.be, pm.wdata & m}, {be, {wd[7:0], bm ? {2{wd[7:0]}} : wd} & m});
        end while (rsp_valid !== 1'b1 && n < 20);
        check(n, !pmx ? 1 : !tb ? ((mv || rp) ? 4 : 5) : (op >= OP_TBL_WR_LO) ? 2 : 3);
        check(rsp_pm, pmx);
        e = !tb ? w[15:0] : hi ? (bm && ea[0] ? 16'h0 : {8'h0, w[23:16]}) : bm ? {8'h0, ea[0] ? w[15:8] : w[7:0]} : w[15:0];
        if (pmx && op <= OP_TBL_RD_HI) check(rsp_data & (bm && tb ? 16'h00ff : 16'hffff), e & (bm && tb ? 16'h00ff : 16'hffff));
    endtask : core

    // ------------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles > 8000) begin
            mismatches++;
            test_done();
        end
    end

    initial begin
        {rst, seed} = {1'b1, 32'd49};
        {wb_cyc, wb_stb, wb_we, req_valid, wb_adr, wb_wdat, req} = '0;
        {mismatches, compares, cycles, tps, vps, vwe} = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values, then an unmapped place that reads zero
        probe = '{PSAM_TPS_OFF, PSAM_VPS_OFF, PSAM_CCR_OFF, PSAM_STAT_OFF, 8'h20};
        foreach (probe[k]) begin
            wb(1'b0, probe[k], 32'h0);
            check(q, 32'h0);
        end
        wb(1'b1, 8'h20, rnd());
        wb(1'b0, 8'h20, 32'h0);
        check(q, 32'h0);
        for (int i = 0; i < 16; i++) begin
            wb(1'b1, PSAM_BREV_OFF, i);
            wb(1'b0, PSAM_BREV_OFF, 32'h0);
            check(q[11:8], {i[0], i[1], i[2], i[3]});
        end
        for (int it = 0; it < 40; it++) begin
            tps = rnd();
            vps = rnd();
            vwe = rnd();
            wb(1'b1, PSAM_TPS_OFF, {24'h0, tps});
            wb(1'b1, PSAM_VPS_OFF, {24'h0, vps});
            wb(1'b1, PSAM_CCR_OFF, {29'h0, vwe, 2'b00});
            wb(1'b0, PSAM_TPS_OFF, 32'h0);
            check(q[7:0], tps);
            for (int k = 0; k < 5; k++) begin
                q = rnd();
                core(psam_op_e'(k), k != 0 && q[0], q[1], q[2], q[31:16], q[15:3]);
            end
        end
        test_done();
    end
endmodule : testbench
`default_nettype wire
